// file: core/ssptx_clkgen.sv
// Serial clock source and internal shift clock generator
`timescale 1ns/100ps
module ssptx_clkgen
    import ssptx_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    // Configuration
    input  wire logic [3:0] baud_code,
    input  wire logic       sync_sel,
    input  wire logic       start_detect,
    // Serial clock pin
    input  wire logic       sclk_in,
    output      logic       sclk_out,
    output      logic       sclk_oe,
    // Shift events
    ssptx_link_if.clk_src   link
);
    logic        ext_s1_reg;
    logic        ext_s2_reg;
    logic        ext_s3_reg;
    logic [11:0] div_cnt_reg;
    logic        int_clk_reg;
    logic [3:0]  sub_cnt_reg;
    logic        internal;
    logic [11:0] half_m1;
    logic        ser_rise;
    logic        ser_fall;

    assign internal = (baud_code != BAUD_EXTERNAL);
    assign half_m1  = (ssptx_baud_div(baud_code) >> 1) - 12'h001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            ext_s3_reg <= 1'b1;
        end else if (ce) begin
            ext_s1_reg <= sclk_in;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // Idles high so the first half period out is high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_reg <= 12'h000;
            int_clk_reg <= 1'b1;
        end else if (ce) begin
            if (!internal) begin
                div_cnt_reg <= 12'h000;
                int_clk_reg <= 1'b1;
            end else if (div_cnt_reg >= half_m1) begin
                div_cnt_reg <= 12'h000;
                int_clk_reg <= ~int_clk_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + 12'h001;
            end
        end
    end

    assign ser_rise = internal ? (div_cnt_reg >= half_m1 && !int_clk_reg)
                               : (ext_s2_reg && !ext_s3_reg);
    assign ser_fall = internal ? (div_cnt_reg >= half_m1 && int_clk_reg)
                               : (!ext_s2_reg && ext_s3_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_cnt_reg <= 4'h0;
        end else if (ce) begin
            if (start_detect || sync_sel) begin
                sub_cnt_reg <= 4'h0;
            end else if (ser_rise) begin
                sub_cnt_reg <= sub_cnt_reg + 4'h1;
            end
        end
    end

    assign link.shift_rise = !start_detect &&
        (sync_sel ? ser_rise : (ser_rise && sub_cnt_reg == ASYNC_RISE_AT));
    assign link.shift_fall = !start_detect &&
        (sync_sel ? ser_fall : (ser_rise && sub_cnt_reg == ASYNC_FALL_AT));

    assign sclk_out = int_clk_reg;
    assign sclk_oe  = internal;
endmodule : ssptx_clkgen

// file: core/ssptx_shifter.sv
// Sixteen-bit shift register with serial input and output stages
`timescale 1ns/100ps
module ssptx_shifter
    import ssptx_pkg::*;
(
    // Clock and reset
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire logic     ce,
    // Serial pins
    input  wire logic     si_pin,
    output      logic     so_pin,
    // Control side
    ssptx_link_if.shifter link
);
    logic        si_s1_reg;
    logic        si_s2_reg;
    logic [15:0] sr_reg;
    logic        so_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            si_s1_reg <= 1'b1;
            si_s2_reg <= 1'b1;
        end else if (ce) begin
            si_s1_reg <= si_pin;
            si_s2_reg <= si_s1_reg;
        end
    end

    assign link.sr_shifted = {si_s2_reg, sr_reg[15:1]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_reg <= 16'h0000;
        end else if (ce && link.shift_rise) begin
            sr_reg <= link.load ? link.load_word : link.sr_shifted;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            so_reg <= 1'b1;
        end else if (ce && link.shift_fall) begin
            so_reg <= link.mark ? 1'b1 : sr_reg[0];
        end
    end

    assign so_pin = so_reg;
endmodule : ssptx_shifter

// file: core/ssptx_top.sv
// Serial shift port transmitter with AXI4-Lite register access
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module ssptx_top
    import ssptx_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset and enable
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output      logic              s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output      logic              s_axi_wready,
    // AXI4-Lite write response
    output      logic [1:0]        s_axi_bresp,
    output      logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output      logic              s_axi_arready,
    // AXI4-Lite read data
    output      logic [31:0]       s_axi_rdata,
    output      logic [1:0]        s_axi_rresp,
    output      logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Serial pins
    input  wire logic              serial_clock_pin_in,
    output      logic              serial_clock_pin_out,
    output      logic              serial_clock_pin_oe,
    input  wire logic              serial_in,
    output      logic              serial_out,
    // Interrupt request
    output      logic              serial_irq,
    output      logic [7:0]        irq_vector
);
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 32");
    end

    ssptx_link_if link ();

    logic [7:0]        ctrl_reg;
    logic [3:0]        baud_reg;
    logic [15:0]       txbuf_reg;
    logic [15:0]       rxbuf_reg;
    logic              ready_reg;
    logic              error_reg;
    logic              new_data_reg;
    ssptx_state_e      state_reg;
    ssptx_state_e      state_next;
    logic [4:0]        bit_cnt_reg;
    logic              irq_reg;

    logic              aw_full_reg;
    logic              w_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    logic              wr_fire;
    logic              wr_byte;
    logic              wr_ctrl;
    logic              wr_baud;
    logic              wr_hi;
    logic              wr_lo;
    logic              wr_map;
    logic              rd_fire;
    logic              rd_stat;
    logic [7:0]        new_ctrl;

    logic              int_en;
    logic              sync_sel;
    logic              xmit_sel;
    logic              search;
    logic              start_det;
    logic [4:0]        word_len;
    logic              eow;
    logic              xfer;

    // Register decode shared by both bus paths
    function automatic logic is_ofs(input logic [ADDR_W-1:0] a, input logic [7:0] o);
        return a == ADDR_W'(o);
    endfunction : is_ofs

    assign int_en    = ctrl_reg[CB_INT_EN];
    assign sync_sel  = ctrl_reg[CB_SYNC];
    assign xmit_sel  = ctrl_reg[CB_XMIT];
    assign search    = ctrl_reg[CB_SEARCH];
    assign start_det = ctrl_reg[CB_START_DET];
    assign word_len  = ssptx_word_len(ctrl_reg[CB_WLEN_LSB +: 3]);

    // Write channel: address and data taken in either order
    assign s_axi_awready = ce && !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = ce && !w_full_reg && !bvalid_reg;
    assign wr_fire       = ce && aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_byte       = wr_fire && w_strb_reg[0];
    assign wr_ctrl       = wr_byte && is_ofs(aw_addr_reg, OFS_CTRL);
    assign wr_baud       = wr_byte && is_ofs(aw_addr_reg, OFS_BAUD);
    assign wr_hi         = wr_byte && is_ofs(aw_addr_reg, OFS_BUF_HI);
    assign wr_lo         = wr_byte && is_ofs(aw_addr_reg, OFS_BUF_LO);
    assign wr_map        = is_ofs(aw_addr_reg, OFS_CTRL) || is_ofs(aw_addr_reg, OFS_BAUD)
                        || is_ofs(aw_addr_reg, OFS_STAT) || is_ofs(aw_addr_reg, OFS_BUF_HI)
                        || is_ofs(aw_addr_reg, OFS_BUF_LO);
    assign new_ctrl      = w_data_reg[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // Status is read-only, so a write there is refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wr_map && !is_ofs(aw_addr_reg, OFS_STAT)) ? RESP_OKAY
                                                                          : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // Read channel
    assign s_axi_arready = ce && !rvalid_reg;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign rd_stat       = rd_fire && is_ofs(s_axi_araddr, OFS_STAT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ce) begin
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= RESP_OKAY;
                rdata_reg  <= 32'h0000_0000;
                if (is_ofs(s_axi_araddr, OFS_CTRL)) begin
                    rdata_reg[7:0] <= ctrl_reg;
                end else if (is_ofs(s_axi_araddr, OFS_BAUD)) begin
                    rdata_reg[3:0] <= baud_reg;
                end else if (is_ofs(s_axi_araddr, OFS_STAT)) begin
                    rdata_reg[SB_READY] <= ready_reg;
                    rdata_reg[SB_ERROR] <= error_reg;
                    rdata_reg[SB_MARK]  <= link.mark;
                end else if (is_ofs(s_axi_araddr, OFS_BUF_HI)) begin
                    rdata_reg[7:0] <= rxbuf_reg[15:8];
                end else if (is_ofs(s_axi_araddr, OFS_BUF_LO)) begin
                    rdata_reg[7:0] <= rxbuf_reg[7:0];
                end else begin
                    rresp_reg <= RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= CTRL_RESET;
            baud_reg <= BAUD_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_reg <= new_ctrl;
            end
            if (wr_baud) begin
                baud_reg <= w_data_reg[3:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txbuf_reg <= 16'h0000;
        end else if (ce) begin
            if (wr_hi) begin
                txbuf_reg[15:8] <= w_data_reg[7:0];
            end
            if (wr_lo) begin
                txbuf_reg[7:0] <= w_data_reg[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt_reg <= 5'h00;
        end else if (ce) begin
            if (wr_ctrl) begin
                bit_cnt_reg <= 5'h00;
            end else if (link.shift_rise) begin
                bit_cnt_reg <= (search || eow) ? 5'h00 : bit_cnt_reg + 5'h01;
            end
        end
    end

    assign eow = link.shift_rise && !search && !wr_ctrl
              && (bit_cnt_reg == word_len - 5'h01);

    always_comb begin
        xfer = 1'b0;
        unique case (state_reg)
            ST_IDLE:  xfer = 1'b0;
            ST_DELAY: xfer = eow;
            ST_SEND:  xfer = eow && (sync_sel || new_data_reg);
            ST_MARK:  xfer = eow && new_data_reg;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        if (wr_ctrl) begin
            if (!new_ctrl[CB_XMIT]) begin
                state_next = ST_IDLE;
            end else if (!xmit_sel) begin
                state_next = ST_DELAY;
            end
        end else if (xfer) begin
            state_next = ST_SEND;
        end else if (eow && state_reg == ST_SEND && !sync_sel) begin
            state_next = ST_MARK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            new_data_reg <= 1'b0;
        end else if (ce) begin
            if (wr_hi || wr_lo) begin
                new_data_reg <= 1'b1;
            end else if (xfer) begin
                new_data_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_reg <= 1'b0;
        end else if (ce) begin
            if (xfer) begin
                ready_reg <= 1'b1;
            end else if (wr_hi || wr_lo) begin
                ready_reg <= 1'b0;
            end
        end
    end

    // underflow error, set wins over read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_reg <= 1'b0;
        end else if (ce) begin
            if (eow && state_reg == ST_SEND && !new_data_reg) begin
                error_reg <= 1'b1;
            end else if (rd_stat) begin
                error_reg <= 1'b0;
            end
        end
    end

    // receive capture at end of word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxbuf_reg <= 16'h0000;
        end else if (ce && eow && xmit_sel && sync_sel) begin
            rxbuf_reg <= link.sr_shifted;
        end
    end

    // transfer interrupt; search interrupts per bit in sync transmit mode only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= int_en && (xfer || (link.shift_rise && search && xmit_sel && sync_sel));
        end
    end

    assign serial_irq = irq_reg;
    assign irq_vector = IRQ_VECTOR;

    assign link.load      = xfer;
    assign link.load_word = txbuf_reg;
    // Idle line sits at mark outside an active word stream
    assign link.mark      = (state_reg != ST_SEND);

    ssptx_clkgen u_clkgen (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .baud_code    (baud_reg),
        .sync_sel     (sync_sel),
        .start_detect (start_det),
        .sclk_in      (serial_clock_pin_in),
        .sclk_out     (serial_clock_pin_out),
        .sclk_oe      (serial_clock_pin_oe),
        .link         (link)
    );

    ssptx_shifter u_shifter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .si_pin  (serial_in),
        .so_pin  (serial_out),
        .link    (link)
    );
endmodule : ssptx_top

// file: include/ssptx_link_if.sv
// Shift events and word handoff between transmitter modules
`timescale 1ns/100ps
interface ssptx_link_if;
    logic        shift_rise;
    logic        shift_fall;
    logic        load;
    logic        mark;
    logic [15:0] load_word;
    logic [15:0] sr_shifted;

    modport clk_src (output shift_rise, output shift_fall);
    modport shifter (input shift_rise, input shift_fall, input load, input mark,
                     input load_word, output sr_shifted);
    modport ctrl    (input shift_rise, input shift_fall, input sr_shifted,
                     output load, output mark, output load_word);
endinterface : ssptx_link_if

// file: include/ssptx_pkg.sv
// Shared constants, types and helpers of the serial shift port transmitter
package ssptx_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BAUD   = 8'h04;
    localparam logic [7:0] OFS_STAT   = 8'h08;
    localparam logic [7:0] OFS_BUF_HI = 8'h0C;
    localparam logic [7:0] OFS_BUF_LO = 8'h10;

    // Control field positions
    localparam int CB_INT_EN    = 0;
    localparam int CB_SYNC      = 1;
    localparam int CB_XMIT      = 2;
    localparam int CB_SEARCH    = 3;
    localparam int CB_START_DET = 4;
    localparam int CB_WLEN_LSB  = 5;

    // Status field positions
    localparam int SB_READY = 0;
    localparam int SB_ERROR = 1;
    localparam int SB_MARK  = 2;

    // Reset values and the external clock code
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [3:0] BAUD_RESET    = 4'h0;
    localparam logic [3:0] BAUD_EXTERNAL = 4'h0;

    localparam logic [3:0] ASYNC_RISE_AT = 4'h7;
    localparam logic [3:0] ASYNC_FALL_AT = 4'hF;
    localparam logic [7:0] IRQ_VECTOR    = 8'hE0;
    localparam logic [1:0] RESP_OKAY     = 2'b00;
    localparam logic [1:0] RESP_SLVERR   = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_SEND  = 2'b11,
        ST_MARK  = 2'b10
    } ssptx_state_e;

    // Word length in bits from the length field
    function automatic logic [4:0] ssptx_word_len(input logic [2:0] code);
        return (code == 3'h7) ? 5'h10 : {2'h0, code} + 5'h04;
    endfunction : ssptx_word_len

    // Internal baud divisor in aclk cycles
    function automatic logic [11:0] ssptx_baud_div(input logic [3:0] code);
        case (code)
            4'hA:    return 12'h030;
            4'h9:    return 12'h060;
            4'h8:    return 12'h0C0;
            4'h7:    return 12'h180;
            4'h6:    return 12'h300;
            4'h5:    return 12'h600;
            4'h4:    return 12'h830;
            4'h3:    return 12'hC00;
            default: return 12'h018;
        endcase
    endfunction : ssptx_baud_div

endpackage : ssptx_pkg

// file: verification/serial_shift_port_transmit_test.sv
// Self-checking bench of the serial shift port transmitter
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module serial_shift_port_transmit_test
    import ssptx_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, irq_vector;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial_in, serial_out, serial_irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
    logic serial_clock_pin_out, serial_clock_pin_oe, serial_clock_pin_in;
    logic [15:0] so_word, si_word, rx;
    logic [15:0] q[$];
    int err_count = 0, checks_done = 0, n;
    // External clock stands still; internal one loops back
    assign serial_clock_pin_in = (serial_clock_pin_oe === 1'b1) ? serial_clock_pin_out : 1'b1;
    always #10 aclk = ~aclk;
    ssptx_top u_dut (.*);
    ssptx_station u_st (.sclk(serial_clock_pin_in), .so(serial_out), .si(serial_in),
                        .so_word(so_word), .si_word(si_word));
    task automatic results;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic stop_on(input bit t);
        if (t) begin
            err_count++;
            results();
        end
    endtask : stop_on
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 50 && !(s_axi_bvalid && s_axi_bready); k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        wr_r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        stop_on(k >= 50);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 50 && !(s_axi_rvalid && s_axi_rready); k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        stop_on(k >= 50);
    endtask : rd
    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (serial_irq !== 1'b1 && n < lim);
    endtask : wait_irq
    initial begin
        void'($urandom(94));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CTRL);
        `CHK("ctrl", 32'h0, rd_d)
        rd(OFS_BAUD);
        `CHK("baud", 32'h0, rd_d)
        rd(8'h14);
        `CHK("unmapped", RESP_SLVERR, rd_r)
        wr(OFS_STAT, 8'h07);
        `CHK("stat_wr", RESP_SLVERR, wr_r)
        $display("test reset done");
        q = {16'($urandom), 16'($urandom)};
        q.push_back(q[1]);
        wr(OFS_BAUD, 8'h0B);
        `CHK("baud_wr", RESP_OKAY, wr_r)
        wr(OFS_BUF_HI, q[0][15:8]);
        wr(OFS_BUF_LO, q[0][7:0]);
        wr(OFS_CTRL, 8'hE7);
        wait_irq(1000);
        stop_on(n >= 1000);
        `CHK("delay", 1'b1, n > 360 && n < 460)
        rd(OFS_STAT);
        `CHK("ready", 1'b1, rd_d[SB_READY])
        // next word well within a word time
        wr(OFS_BUF_HI, q[1][15:8]);
        wr(OFS_BUF_LO, q[1][7:0]);
        rd(OFS_STAT);
        `CHK("ready_clr", 1'b0, rd_d[SB_READY])
        for (int k = 0; k < 3; k++) begin
            wait_irq(1000);
            stop_on(n >= 1000);
            rx = si_word;
            `CHK("so_word", q[k], so_word)
            if (k == 0) begin
                rd(OFS_BUF_HI);
                `CHK("rx_hi", rx[15:8], rd_d[7:0])
                rd(OFS_BUF_LO);
                `CHK("rx_lo", rx[7:0], rd_d[7:0])
            end
        end
        rd(OFS_STAT);
        `CHK("underflow", 1'b1, rd_d[SB_ERROR])
        // Search on: one request per shift rise, not per word
        wr(OFS_CTRL, 8'h0F);
        repeat (2) begin
            wait_irq(100);
            `CHK("search", 1'b1, n < 30)
        end
        $display("test sync done");
        wr(OFS_CTRL, 8'h00);
        wr(OFS_BUF_LO, 8'h00);
        wait_irq(500);
        `CHK("rx_mode", 1'b1, serial_out)
        rd(OFS_STAT);
        `CHK("no_load", 1'b0, rd_d[SB_READY])
        wr(OFS_CTRL, 8'hF7);
        wait_irq(1500);
        `CHK("stopped", 1500, n)
        $display("test stop done");
        wr(OFS_CTRL, 8'h00);
        q[0] = 16'($urandom);
        wr(OFS_BUF_HI, q[0][15:8]);
        wr(OFS_BUF_LO, q[0][7:0]);
        wr(OFS_CTRL, 8'hE5);
        rd(OFS_STAT);
        wait_irq(8000);
        stop_on(n >= 8000);
        rd_d = 32'h0;
        for (n = 0; n < 4000 && rd_d[SB_ERROR] !== 1'b1; n++) rd(OFS_STAT);
        stop_on(n >= 4000);
        `CHK("mark", 3'h7, rd_d[2:0])
        // Last bit stands until the next shift fall
        repeat (400) @(posedge aclk);
        `CHK("mark_out", 1'b1, serial_out)
        $display("test async done");
        results();
    end
endmodule : serial_shift_port_transmit_test

// file: verification/ssptx_props.sv
// Port-level checker of the serial shift port transmitter
`timescale 1ns/100ps
module ssptx_props (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Read channel
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // Serial side
    input wire logic       serial_clock_pin_oe,
    input wire logic       serial_out,
    input wire logic       serial_irq,
    input wire logic [7:0] irq_vector
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_idle_a: assert property ($rose(aresetn) |-> serial_out && !serial_irq)
        else $error("outputs busy after reset");
    reset_clk_a: assert property ($rose(aresetn) |-> !serial_clock_pin_oe)
        else $error("clock pin driven after reset");
    irq_vec_a: assert property (irq_vector == 8'hE0)
        else $error("wrong vector");
    irq_pulse_a: assert property (serial_irq |=> !serial_irq)
        else $error("irq longer than one cycle");
    out_hold_a: assert property ($changed(serial_out) |=> $stable(serial_out) [*8])
        else $error("output bit too short");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
endmodule : ssptx_props

bind ssptx_top ssptx_props u_props (.*);

// file: verification/ssptx_station.sv
// Remote serial station driving and capturing the data pins
`timescale 1ns/100ps
module ssptx_station (
    // Clock on the wire
    input  wire logic        sclk,
    // Data lines
    input  wire logic        so,
    output      logic        si,
    // Last sixteen samples, first one lowest
    output      logic [15:0] so_word,
    output      logic [15:0] si_word
);
    initial si = 1'b0;
    always @(posedge sclk) begin
        so_word <= {so, so_word[15:1]};
        si_word <= {si, si_word[15:1]};
    end
    // Changing far from the sampling edge
    always @(negedge sclk) begin
        // Unfilled samples count as zero, so the pattern never locks at unknown
        si <= ~si ^ (si_word[4] === 1'b1) ^ (si_word[9] === 1'b1);
    end
endmodule : ssptx_station
